// ===== rtl/frg_fault_record_top.sv
/*
  Fault record, parameter presence map and peer fault group block.
  Holds the live record image, stores it on faults, serves the block
  reads and writes of the command layer, and filters peer fault events.
  Assumes all inputs come from logic on clk_sys_in (no synchronisers)
  and that telemetry words are already in their bus formats.
*/
// Overview of operation
// (R1) Record read returns exactly 32 bytes
// (R2) Live record image refreshed during operation
// (R3) Fault copies latest image into store
// (R4) Host writes 01h to control before reading
// (R5) Bytes 31:22 hold five Linear-11 readings
// (R6) Bytes 21:16 hold six status byte copies
// (R7) Bytes 15:14 hold highest output current
// (R8) Bytes 13:8 hold current, voltage, input
// (R9) Fault fields, first fault, uptime, flash
// (R10) First-fault byte marks one earliest fault
// (R11) Fault field bits 15:8 flag events
// (R12) Fault field bits 7:0 flag events
// (R13) Presence map 256 bits, ones at reset
// (R14) Restore or write clears presence bit
// (R15) Group mask 32 bits, resets zero
// (R16) Peer fault acted on only if bit set
// (R17) Host should not set own rail bit
// (R18) Spreading on: shut down, no retries
// (R19) Sequencing only: immediate off, no retries
// (R20) Both off: ignore peers, stay enabled
// (R21) Shared rail down only when all down
// (R22) Armed control captures at next fault
// (R23) Control bits 4:2 choose stored record
// (R24) Image updated as one coherent set
`timescale 1ns/1ps
module frg_fault_record_top
  import frg_pkg::*;
#(
  parameter int RECORDS = 8,
  parameter int SHARE_N = 8,
  parameter int TICK_CYC = frg_pkg::UPTIME_TICK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Command port from the bus layer
  input wire logic wr_stb_in,
  input wire logic [7:0] wr_code_in,
  input wire logic [4:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_stb_in,
  input wire logic [7:0] rd_code_in,
  input wire logic [4:0] rd_idx_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic [5:0] rd_len_out,
  // Telemetry sample set
  input wire logic sample_stb_in,
  input wire logic [15:0] duty_in,
  input wire logic [15:0] freq_in,
  input wire logic [15:0] temp_ext2_in,
  input wire logic [15:0] temp_ext1_in,
  input wire logic [15:0] temp_int_in,
  input wire logic [47:0] status_bytes_in,
  input wire logic [15:0] peak_iout_in,
  input wire logic [15:0] iout_in,
  input wire logic [15:0] vout_in,
  input wire logic [15:0] vin_in,
  input wire logic [7:0] flash_status_in,
  // Local fault events and their mask
  input wire logic [15:0] fault_evt_in,
  input wire logic [15:0] fault_mask_in,
  input wire logic clear_faults_in,
  // Store restore events
  input wire logic restore_start_in,
  input wire logic restore_stb_in,
  input wire logic [7:0] restore_code_in,
  // Inter-device bus peer fault events and mode
  input wire logic peer_evt_in,
  input wire logic [4:0] peer_id_in,
  input wire logic spread_en_in,
  input wire logic seq_en_in,
  input wire logic rail_enable_in,
  // Current share members
  input wire logic own_off_in,
  input wire logic [SHARE_N-1:0] share_used_in,
  input wire logic [SHARE_N-1:0] share_down_in,
  output logic shutdown_out,
  output logic no_retry_out,
  output logic no_ramp_out,
  output logic rail_down_out
);

  localparam int AW = $clog2(RECORDS);

  frg_state_s st; // Registered state
  frg_state_s next_st; // Next state
  logic [255:0] live; // Image with live fault fields overlaid
  logic [255:0] src; // Block source for a read starting at byte 0
  logic [15:0] evt; // Unmasked local fault events
  logic peer_hit; // Peer event from a listened rail
  logic [15:0] rc_wr; // Control word after a byte write
  logic cap_go; // Armed capture fires on this edge

  frg_mem_if #(.WIDTH(256), .AW(AW)) mem_bus ();

  // Stored record memory
  frg_record_mem #(.WIDTH(256), .DEPTH(RECORDS), .AW(AW)) u_mem (
    .clk_sys_in(clk_sys_in),
    .port(mem_bus)
  );

  // Overlay of fault fields onto the sampled telemetry
  always_comb begin
    live = st.image;
    // (R9) fault fields placed
    live[BY_ALL_FAULTS*8 +: 16] = st.all_faults;
    live[BY_FIRST*8 +: 8] = st.first;
    live[BY_UPTIME*8 +: 32] = st.uptime;
    live[BY_FLASH*8 +: 8] = flash_status_in;
  end

  // Memory port drive; the store write lands on the fault edge, straight
  // from the live image, so a block read in flight keeps its frozen copy
  always_comb begin
    // (R3) store latest image
    mem_bus.we = cap_go;
    mem_bus.waddr = st.wr_ptr[AW-1:0];
    mem_bus.wdata = live;
    // (R23) stored record select
    mem_bus.raddr = st.rec_ctl[RC_LOC_LO +: AW];
  end

  // Combinational terms used by the next-state process
  always_comb begin
    evt = fault_evt_in & ~fault_mask_in;
    // (R16) group bit gates peer
    peer_hit = peer_evt_in & st.group[peer_id_in];
    // (R22) armed capture on fault
    cap_go = (st.cap == CAP_IDLE) && st.rec_ctl[RC_ARMED] && (|evt) &&
      (st.avail != 4'h0);
    rc_wr = st.rec_ctl;
    if (wr_idx_in == 5'h00) begin
      rc_wr[7:0] = wr_data_in;
    end else begin
      rc_wr[15:8] = wr_data_in;
    end
    rc_wr = (rc_wr & RC_WR_MASK) | {4'h0, st.avail, 8'h00};
    // (R4) enable bit selects stored view
    if (st.rec_ctl[RC_ENABLE]) begin
      src = mem_bus.rdata;
    end else begin
      src = live;
    end
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.shutdown = 1'b0;

    // (R2) refresh image on sample
    if (sample_stb_in) begin
      // (R24) all fields in one edge
      // (R5) Linear-11 readings
      next_st.image[BY_DUTY*8 +: 16] = duty_in;
      next_st.image[BY_FREQ*8 +: 16] = freq_in;
      next_st.image[BY_TEMP_EXT2*8 +: 16] = temp_ext2_in;
      next_st.image[BY_TEMP_EXT1*8 +: 16] = temp_ext1_in;
      next_st.image[BY_TEMP_INT*8 +: 16] = temp_int_in;
      // (R6) status bytes, manufacturer high
      next_st.image[BY_STATUS*8 +: 48] = status_bytes_in;
      // (R7) highest output current
      next_st.image[BY_PEAK_IOUT*8 +: 16] = peak_iout_in;
      // (R8) current, voltage, input
      next_st.image[BY_IOUT*8 +: 16] = iout_in;
      next_st.image[BY_VOUT*8 +: 16] = vout_in;
      next_st.image[BY_VIN*8 +: 16] = vin_in;
    end

    // Uptime counter; a one-cycle enable from the divider
    if (st.tick_cnt == 25'(TICK_CYC - 1)) begin
      next_st.tick_cnt = 25'h0000000;
      next_st.uptime = st.uptime + 32'h00000001;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 25'h0000001;
    end

    // Clear first so that a same-cycle event still lands
    if (clear_faults_in) begin
      next_st.all_faults = 16'h0000;
      next_st.first = 8'h00;
    end
    // (R11) upper event flags
    // (R12) lower event flags
    next_st.all_faults = next_st.all_faults | evt;
    if (peer_hit) begin
      next_st.all_faults[AF_GROUP] = 1'b1;
    end
    // (R10) one earliest fault only
    if (next_st.first == 8'h00) begin
      if (evt[AF_PEAK_OC]) begin
        next_st.first[FF_PEAK_OC] = 1'b1;
      end else if (evt[AF_AVG_OC]) begin
        next_st.first[FF_AVG_OC] = 1'b1;
      end else if (evt[AF_FIRST_OUT_OVERVOLTAGE]) begin
        next_st.first[FF_OUT_OV] = 1'b1;
      end else if (evt[AF_FIRST_IN_UNDERVOLTAGE]) begin
        next_st.first[FF_IN_UV] = 1'b1;
      end
    end

    // Capture sequencer: store write on entry, slot bookkeeping after;
    // a second fault during bookkeeping cannot reuse the same slot
    case (st.cap)
      CAP_IDLE: begin
        // (R22) armed capture on fault
        if (cap_go) begin
          next_st.cap = CAP_WRITE;
        end
      end
      CAP_WRITE: begin
        next_st.wr_ptr = st.wr_ptr + 3'h1;
        next_st.avail = st.avail - 4'h1;
        next_st.cap = CAP_IDLE;
      end
      default: begin
        next_st.cap = CAP_IDLE;
      end
    endcase

    // (R13) restore start: all absent
    if (restore_start_in) begin
      next_st.presence = PRESENCE_RST;
    end
    // (R14) restored value clears bit
    if (restore_stb_in) begin
      next_st.presence[restore_code_in] = 1'b0;
    end

    // Host writes; read-only blocks ignore data
    if (wr_stb_in) begin
      // (R14) written command clears bit
      next_st.presence[wr_code_in] = 1'b0;
      if (wr_code_in == CMD_GROUP_MASK && wr_idx_in < 5'h04) begin
        // (R15) byte 0 bit 0 is rail 0
        next_st.group[wr_idx_in[1:0]*8 +: 8] = wr_data_in;
      end
      if (wr_code_in == CMD_RECORD_CTL && wr_idx_in < 5'h02) begin
        if (wr_idx_in == 5'h00 && wr_data_in[RC_ERASE]) begin
          // Erase stands alone; other bits of that write are dropped
          next_st.avail = RECORDS_ALL;
          next_st.wr_ptr = 3'h0;
        end else begin
          next_st.rec_ctl = rc_wr;
        end
      end
    end
    next_st.rec_ctl[11:8] = next_st.avail;

    // Host reads; byte 0 of a record or map read freezes the whole block for the transfer
    if (rd_stb_in) begin
      next_st.rd_valid = 1'b1;
      next_st.rd_data = 8'h00;
      next_st.rd_len = 6'h00;
      case (rd_code_in)
        CMD_FAULT_RECORD: begin
          // (R1) 32-byte block
          next_st.rd_len = LEN_RECORD;
          if (rd_idx_in == 5'h00) begin
            next_st.rd_buf = src;
          end
          next_st.rd_data = next_st.rd_buf[rd_idx_in*8 +: 8];
        end
        CMD_PRESENCE_MAP: begin
          // (R13) 256-bit read-only map
          next_st.rd_len = LEN_MAP;
          if (rd_idx_in == 5'h00) begin
            next_st.rd_buf = st.presence;
          end
          next_st.rd_data = next_st.rd_buf[rd_idx_in*8 +: 8];
        end
        CMD_GROUP_MASK: begin
          next_st.rd_len = LEN_GROUP;
          if (rd_idx_in < 5'h04) begin
            next_st.rd_data = st.group[rd_idx_in[1:0]*8 +: 8];
          end
        end
        CMD_RECORD_CTL: begin
          next_st.rd_len = LEN_CTL;
          if (rd_idx_in == 5'h00) begin
            next_st.rd_data = st.rec_ctl[7:0];
          end else if (rd_idx_in == 5'h01) begin
            next_st.rd_data = st.rec_ctl[15:8];
          end
        end
        default: begin
          // Unserved code: zero length tells the bus layer to refuse
          next_st.rd_len = 6'h00;
        end
      endcase
    end

    // Peer fault response; flags drop once the rail is disabled
    if (!rail_enable_in) begin
      next_st.no_retry = 1'b0;
      next_st.no_ramp = 1'b0;
    end
    if (peer_hit) begin
      if (spread_en_in) begin
        // (R18) shut down, no retry
        next_st.shutdown = 1'b1;
        next_st.no_retry = 1'b1;
      end else if (seq_en_in) begin
        // (R19) off without ramp-down
        next_st.shutdown = 1'b1;
        next_st.no_retry = 1'b1;
        next_st.no_ramp = 1'b1;
      end
      // (R20) both off: no shutdown or flags, only the group fault bit set above
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
      st.cap <= CAP_IDLE;
      st.presence <= PRESENCE_RST;
      // (R15) group resets to zero
      st.group <= GROUP_RST;
      st.rec_ctl <= RC_RST | {4'h0, RECORDS_ALL, 8'h00};
      st.avail <= RECORDS_ALL;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign rd_data_out = st.rd_data;
  assign rd_valid_out = st.rd_valid;
  assign rd_len_out = st.rd_len;
  assign shutdown_out = st.shutdown;
  assign no_retry_out = st.no_retry;
  assign no_ramp_out = st.no_ramp;
  // (R21) all sharing members down
  assign rail_down_out = own_off_in & (&(share_down_in | ~share_used_in));

endmodule

// ===== rtl/frg_mem_if.sv
/*
  Carrier between the record controller and the stored record memory.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface frg_mem_if #(
  parameter int WIDTH = 256,
  parameter int AW = 3
);
  logic we; // Write strobe, one cycle
  logic [AW-1:0] waddr; // Record slot written
  logic [WIDTH-1:0] wdata; // Record image written
  logic [AW-1:0] raddr; // Record slot read
  logic [WIDTH-1:0] rdata; // Registered read data

  modport ctl (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface

// ===== rtl/frg_pkg.sv
/*
  Constants and types shared by the fault record and group command block.
  Assumes a command-level host port: the serial bus layer above decodes
  the command code and hands over one byte at a time with its index.
*/
package frg_pkg;

  // Command codes served by the block
  localparam logic [7:0] CMD_FAULT_RECORD = 8'hEA;
  localparam logic [7:0] CMD_PRESENCE_MAP = 8'hEB;
  localparam logic [7:0] CMD_GROUP_MASK = 8'hF0;
  localparam logic [7:0] CMD_RECORD_CTL = 8'hF3;

  // Block lengths in bytes, as reported on rd_len_out
  localparam logic [5:0] LEN_RECORD = 6'h20;
  localparam logic [5:0] LEN_MAP = 6'h20;
  localparam logic [5:0] LEN_GROUP = 6'h04;
  localparam logic [5:0] LEN_CTL = 6'h02;

  // Low byte index of each record field
  localparam int BY_DUTY = 30;
  localparam int BY_FREQ = 28;
  localparam int BY_TEMP_EXT2 = 26;
  localparam int BY_TEMP_EXT1 = 24;
  localparam int BY_TEMP_INT = 22;
  localparam int BY_STATUS = 16;
  localparam int BY_PEAK_IOUT = 14;
  localparam int BY_IOUT = 12;
  localparam int BY_VOUT = 10;
  localparam int BY_VIN = 8;
  localparam int BY_ALL_FAULTS = 6;
  localparam int BY_FIRST = 5;
  localparam int BY_UPTIME = 1;
  localparam int BY_FLASH = 0;

  // Accumulated fault field bit positions
  localparam int AF_RAIL = 15;
  localparam int AF_GROUP = 14;
  localparam int AF_PEAK_OC = 10;
  localparam int AF_FIRST_OUT_OVERVOLTAGE = 6;
  localparam int AF_FIRST_IN_UNDERVOLTAGE = 2;
  localparam int AF_AVG_OC = 1;

  // First-fault byte bit positions
  localparam int FF_PEAK_OC = 3;
  localparam int FF_AVG_OC = 2;
  localparam int FF_OUT_OV = 1;
  localparam int FF_IN_UV = 0;

  // Record control fields
  localparam int RC_ARMED = 15;
  localparam int RC_ENABLE = 0;
  localparam int RC_ERASE = 1;
  localparam int RC_LOC_LO = 2;
  localparam logic [15:0] RC_WR_MASK = 16'h80DD;
  localparam logic [3:0] RECORDS_ALL = 4'h8;

  // Values after reset
  localparam logic [255:0] PRESENCE_RST = {256{1'b1}};
  localparam logic [31:0] GROUP_RST = 32'h00000000;
  localparam logic [15:0] RC_RST = 16'h0000;

  // Uptime tick: one count per second at the system clock
  localparam int CLK_HZ = 20000000;
  localparam int UPTIME_TICK_S = 1;
  localparam int UPTIME_TICK_CYC = CLK_HZ * UPTIME_TICK_S;

  // Capture sequencer states
  typedef enum logic [0:0] {CAP_IDLE, CAP_WRITE} frg_cap_e;

  // Whole state of the main module
  typedef struct packed {
    logic [255:0] image;
    logic [255:0] rd_buf;
    logic [255:0] presence;
    logic [31:0] group;
    logic [15:0] rec_ctl;
    logic [3:0] avail;
    logic [2:0] wr_ptr;
    frg_cap_e cap;
    logic [15:0] all_faults;
    logic [7:0] first;
    logic [31:0] uptime;
    logic [24:0] tick_cnt;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [5:0] rd_len;
    logic shutdown;
    logic no_retry;
    logic no_ramp;
  } frg_state_s;

endpackage

// ===== rtl/frg_record_mem.sv
/*
  Nonvolatile record store model: a small array of fault records with a
  registered read port. Assumes the writer never writes and reads the
  same slot in one cycle with any need for the new data.
*/
`timescale 1ns/1ps
module frg_record_mem #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_sys_in,
  frg_mem_if.mem port
);
  // Record array; no reset, contents are undefined until written
  logic [WIDTH-1:0] mem [DEPTH];

  // Write and registered read in one process
  always_ff @(posedge clk_sys_in) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
    port.rdata <= mem[port.raddr];
  end
endmodule

// ===== test/frg_fault_record_properties.sv
/* Checker for the fault record block: read answers and peer fault modes.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module frg_props
  import frg_pkg::*;
#(
  parameter int SHARE_N = 8
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic rd_stb_in,
  input wire logic [7:0] rd_code_in,
  input wire logic rd_valid_out,
  input wire logic [5:0] rd_len_out,
  input wire logic peer_evt_in,
  input wire logic spread_en_in,
  input wire logic seq_en_in,
  input wire logic shutdown_out,
  input wire logic no_retry_out,
  input wire logic no_ramp_out,
  input wire logic own_off_in,
  input wire logic [SHARE_N-1:0] share_used_in,
  input wire logic [SHARE_N-1:0] share_down_in,
  input wire logic rail_down_out
);
  // One clock domain, so one clocking and one reset for all
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // Record read request, then its shutdown-mode peer hit
  sequence s_rec_rd;
    rd_stb_in && rd_code_in == CMD_FAULT_RECORD;
  endsequence
  sequence s_spread_hit;
    peer_evt_in && spread_en_in ##1 shutdown_out;
  endsequence

  chk_rd_answer: assert property (rd_stb_in |=> rd_valid_out)
    else $error("read strobe got no answer");
  chk_rd_quiet: assert property (!rd_stb_in |=> !rd_valid_out)
    else $error("read answer without a strobe");
  chk_rec_len: assert property (s_rec_rd |=> rd_len_out == LEN_RECORD)
    else $error("record length wrong");
  chk_map_len: assert property (rd_stb_in &&
    rd_code_in == CMD_PRESENCE_MAP |=> rd_len_out == LEN_MAP)
    else $error("map length wrong");
  chk_group_len: assert property (rd_stb_in &&
    rd_code_in == CMD_GROUP_MASK |=> rd_len_out == LEN_GROUP)
    else $error("group length wrong");
  chk_shut_cause: assert property (shutdown_out |-> $past(peer_evt_in))
    else $error("shutdown without a peer event");
  chk_peer_ignored: assert property (peer_evt_in &&
    !spread_en_in && !seq_en_in |=> !shutdown_out)
    else $error("peer fault acted on with both modes off");
  chk_spread_retry: assert property (s_spread_hit |-> no_retry_out)
    else $error("spread shutdown left retries on");
  chk_ramp_mode: assert property ($rose(no_ramp_out) |->
    $past(peer_evt_in && seq_en_in && !spread_en_in))
    else $error("ramp skipped outside sequencing mode");
  chk_retry_mode: assert property ($rose(no_retry_out) |->
    $past(peer_evt_in && (spread_en_in || seq_en_in)))
    else $error("retry blocked without cause");
  chk_rail_down: assert property (rail_down_out |->
    own_off_in && &(share_down_in | ~share_used_in))
    else $error("rail down before all members down");
endmodule

bind frg_fault_record_top frg_props #(.SHARE_N(SHARE_N)) u_frg_props (
  .clk_sys_in, .resetn_in, .rd_stb_in, .rd_code_in, .rd_valid_out,
  .rd_len_out, .peer_evt_in, .spread_en_in, .seq_en_in, .shutdown_out,
  .no_retry_out, .no_ramp_out, .own_off_in, .share_used_in,
  .share_down_in, .rail_down_out);

// ===== test/frg_fault_record_top_tb.sv
/* Bench for the fault record block: command reads, telemetry, faults,
   capture, peers and share rail. Assumes a 4-cycle uptime tick. */
`timescale 1ns/1ps
module frg_fault_record_top_tb;
  import frg_pkg::*;
  typedef struct {logic [7:0] c; logic [4:0] i; logic [7:0] v;
    logic [5:0] n;} frg_row_s;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic wr_stb, rd_stb, smp, clr, rs_go, rs_stb, spread, seq, rail_en;
  logic own_off, rd_valid, peer_evt, shut, no_retry, no_ramp, rail_down;
  logic [7:0] wr_code, wr_data, rd_code, rs_code, fs, d, used, down;
  logic [4:0] wr_idx, rd_idx, peer_id;
  logic [15:0] evt, mask;
  logic [5:0] rd_len;
  logic [255:0] tv, rec_a;
  int fail_count = 0;
  int n_checks = 0;
  // Ordinary reads after setup: code, index, byte, length
  frg_row_s rows[10] = '{'{8'hF0, 5'h00, 8'h24, 6'h04},
    '{8'hF0, 5'h01, 8'h00, 6'h04}, '{8'hF0, 5'h02, 8'h00, 6'h04},
    '{8'hF0, 5'h03, 8'h80, 6'h04}, '{8'hEB, 5'h00, 8'hFB, 6'h20},
    '{8'hEB, 5'h1E, 8'hFE, 6'h20}, '{8'hEB, 5'h1F, 8'hFF, 6'h20},
    '{8'h55, 5'h00, 8'h00, 6'h00}, '{8'hF3, 5'h01, 8'h08, 6'h02},
    '{8'hF3, 5'h00, 8'h00, 6'h02}};

  always #25 clk_sys_in = ~clk_sys_in;

  frg_fault_record_top #(.TICK_CYC(4)) u_frg_fault_record_top (
    .clk_sys_in, .resetn_in, .wr_stb_in(wr_stb), .wr_code_in(wr_code),
    .wr_idx_in(wr_idx), .wr_data_in(wr_data), .rd_stb_in(rd_stb),
    .rd_code_in(rd_code), .rd_idx_in(rd_idx), .rd_data_out(d),
    .rd_valid_out(rd_valid), .rd_len_out(rd_len), .sample_stb_in(smp),
    .duty_in(tv[255:240]), .freq_in(tv[239:224]),
    .temp_ext2_in(tv[223:208]), .temp_ext1_in(tv[207:192]),
    .temp_int_in(tv[191:176]), .status_bytes_in(tv[175:128]),
    .peak_iout_in(tv[127:112]), .iout_in(tv[111:96]),
    .vout_in(tv[95:80]), .vin_in(tv[79:64]), .flash_status_in(fs),
    .fault_evt_in(evt), .fault_mask_in(mask), .clear_faults_in(clr),
    .restore_start_in(rs_go), .restore_stb_in(rs_stb),
    .restore_code_in(rs_code), .peer_evt_in(peer_evt),
    .peer_id_in(peer_id), .spread_en_in(spread), .seq_en_in(seq),
    .rail_enable_in(rail_en), .own_off_in(own_off), .share_used_in(used),
    .share_down_in(down), .shutdown_out(shut), .no_retry_out(no_retry),
    .no_ramp_out(no_ramp), .rail_down_out(rail_down));

  frg_peer_model u_peer (.clk_sys_in, .peer_evt_out(peer_evt),
    .peer_id_out(peer_id), .share_down_out(down));

  // Verdict and end of run, from one place
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Case-equal compare so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %0h wanted %0h", $time, seen, exp);
    end
  endtask
  // One command byte write
  task automatic wr(input logic [7:0] c, input logic [4:0] i,
      input logic [7:0] v);
    @(posedge clk_sys_in);
    wr_stb <= 1'b1;
    wr_code <= c;
    wr_idx <= i;
    wr_data <= v;
    @(posedge clk_sys_in);
    wr_stb <= 1'b0;
  endtask
  // One byte read; the answer stands only for the next cycle
  task automatic rd(input logic [7:0] c, input logic [4:0] i);
    @(posedge clk_sys_in);
    rd_stb <= 1'b1;
    rd_code <= c;
    rd_idx <= i;
    @(posedge clk_sys_in);
    rd_stb <= 1'b0;
    #1;
    chk(rd_valid, 1'b1);
  endtask
  // Whole record read; uptime is never compared, it keeps counting
  task automatic rd_rec(input logic [255:0] e, input bit skipf);
    for (int k = 0; k < 32; k++) begin
      rd(CMD_FAULT_RECORD, k[4:0]);
      if (k == 0) chk(rd_len, LEN_RECORD);
      if ((k == 0 || k > 4) && !(skipf && k > 4 && k < 8))
        chk(d, e[8*k +: 8]);
    end
  endtask
  // New telemetry set, loaded by one sample strobe
  task automatic sample(input int m, input int a);
    logic [255:0] t;
    for (int k = 0; k < 32; k++) t[8*k +: 8] = 8'(k * m + a);
    @(posedge clk_sys_in);
    tv <= t;
    smp <= 1'b1;
    @(posedge clk_sys_in);
    smp <= 1'b0;
  endtask
  // One local fault event pulse
  task automatic fault(input logic [15:0] e);
    @(posedge clk_sys_in);
    evt <= e;
    @(posedge clk_sys_in);
    evt <= 16'h0000;
  endtask
  // Mode change with a rail cycle, then one peer event
  task automatic peer(input logic [4:0] id, input logic sp,
      input logic sq, input logic [2:0] e);
    @(posedge clk_sys_in);
    rail_en <= 1'b0;
    spread <= sp;
    seq <= sq;
    @(posedge clk_sys_in);
    rail_en <= 1'b1;
    u_peer.send(id);
    #1;
    chk({shut, no_retry, no_ramp}, e);
  endtask
  // Share state, then the rail report
  task automatic share(input logic o, input logic [7:0] v, input logic e);
    @(posedge clk_sys_in);
    own_off <= o;
    u_peer.set_down(v);
    #1;
    chk(rail_down, e);
  endtask

  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    stop_test();
  end

  initial begin
    {wr_stb, rd_stb, smp, clr, rs_go, rs_stb, spread, seq} = 8'h00;
    {wr_code, wr_data, rd_code, rs_code, wr_idx, rd_idx} = 42'h0;
    {evt, mask, tv} = '0;
    {rail_en, own_off, fs, used} = {1'b1, 1'b0, 8'h5A, 8'h0F};
    repeat (5) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    // Restore, then a write that clears one more map bit
    @(posedge clk_sys_in);
    rs_go <= 1'b1;
    @(posedge clk_sys_in);
    rs_go <= 1'b0;
    rs_stb <= 1'b1;
    rs_code <= 8'h02;
    @(posedge clk_sys_in);
    rs_stb <= 1'b0;
    // own rail (id 0) left out of the group
    wr(CMD_GROUP_MASK, 5'h00, 8'h24);
    wr(CMD_GROUP_MASK, 5'h03, 8'h80);
    sample(37, 5);
    foreach (rows[i]) begin
      rd(rows[i].c, rows[i].i);
      chk(d, rows[i].v);
      chk(rd_len, rows[i].n);
    end
    rd_rec({tv[255:64], 24'h0, 32'h0, fs}, 1'b0);
    // Masked average OC is dropped; peak OC outranks input UV
    @(posedge clk_sys_in);
    mask <= 16'h0002;
    fault(16'h0406);
    sample(37, 5);
    rd_rec({tv[255:64], 16'h0404, 8'h08, 32'h0, fs}, 1'b0);
    @(posedge clk_sys_in);
    clr <= 1'b1;
    mask <= 16'h0000;
    @(posedge clk_sys_in);
    clr <= 1'b0;
    // Armed capture, then newer live data
    wr(CMD_RECORD_CTL, 5'h01, 8'h80);
    sample(3, 17);
    rec_a = {tv[255:64], 24'h0, 32'h0, fs};
    fault(16'h0040);
    sample(11, 9);
    wr(CMD_RECORD_CTL, 5'h00, 8'h01);
    repeat (2) @(posedge clk_sys_in);
    rd_rec(rec_a, 1'b1);
    rd(CMD_RECORD_CTL, 5'h01);
    chk(d, 8'h87);
    wr(CMD_RECORD_CTL, 5'h00, 8'h00);
    rd_rec({tv[255:64], 16'h0040, 8'h02, 32'h0, fs}, 1'b0);
    // Erase alone refills the free slot count, armed bit kept
    wr(CMD_RECORD_CTL, 5'h00, 8'h02);
    rd(CMD_RECORD_CTL, 5'h01);
    chk(d, 8'h88);
    peer(5'd2, 1'b1, 1'b0, 3'b110);
    peer(5'd3, 1'b1, 1'b0, 3'b000);
    peer(5'd31, 1'b0, 1'b1, 3'b111);
    peer(5'd5, 1'b0, 1'b0, 3'b000);
    // Listened peer hits leave the group fault flag in the record
    rd(CMD_FAULT_RECORD, 5'h00);
    rd(CMD_FAULT_RECORD, 5'h07);
    chk(d, 8'h40);
    share(1'b1, 8'h07, 1'b0);
    share(1'b1, 8'h0F, 1'b1);
    share(1'b0, 8'h0F, 1'b0);
    // Reset in mid-run restores defaults
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(CMD_GROUP_MASK, 5'h03);
    chk(d, 8'h00);
    rd(CMD_PRESENCE_MAP, 5'h00);
    chk(d, 8'hFF);
    // Uptime restarts at reset; one tick after four edges
    rd(CMD_FAULT_RECORD, 5'h00);
    rd(CMD_FAULT_RECORD, 5'h01);
    chk(d, 8'h01);
    stop_test();
  end
endmodule

// ===== test/frg_peer_model.sv
/* Peer controllers on the inter-device bus and share rail members.
   Assumes one bench process calls its tasks. */
`timescale 1ns/1ps
module frg_peer_model #(
  parameter int SHARE_N = 8
) (
  input wire logic clk_sys_in,
  output logic peer_evt_out,
  output logic [4:0] peer_id_out,
  output logic [SHARE_N-1:0] share_down_out
);
  // Quiet bus at start
  initial begin
    peer_evt_out = 1'b0;
    peer_id_out = 5'h00;
    share_down_out = '0;
  end
  // One fault event, one cycle long
  task automatic send(input logic [4:0] id);
    @(posedge clk_sys_in);
    peer_evt_out <= 1'b1;
    peer_id_out <= id;
    @(posedge clk_sys_in);
    peer_evt_out <= 1'b0;
    // Stale id is inverted so a late sample cannot pass by luck
    peer_id_out <= ~id;
  endtask
  // Share members report which of them are off
  task automatic set_down(input logic [SHARE_N-1:0] v);
    @(posedge clk_sys_in);
    share_down_out <= v;
  endtask
endmodule
